// file: rtl/gsbt_defs.svh
// constants for the gated sixteen-bit timer
`ifndef GSBT_DEFS_SVH
`define GSBT_DEFS_SVH
`define GSBT_ADDR_CONTROL   12'h000
`define GSBT_ADDR_COUNT_LOW 12'h004
`define GSBT_ADDR_COUNT_HIGH 12'h008
`define GSBT_ADDR_STATUS    12'h00c
`define GSBT_CTL_TIMER_ON   0
`define GSBT_CTL_GATE_EN    1
`define GSBT_CTL_NO_SYNC    2
`define GSBT_CTL_OSC_EN     3
`define GSBT_CTL_PRESC_LSB  4
`define GSBT_CTL_SRC_LSB    6
`define GSBT_CTL_RESET      8'h00
`define GSBT_CTL_MASK       8'hff
`define GSBT_STS_OVF        0
`define GSBT_STS_OSC_RUN    1
`define GSBT_INSTR_DIV      2'h3
`define GSBT_OSC_SETTLE     10'h3ff
`endif

// file: rtl/gsbt_pkg.sv
// types for the gated sixteen-bit timer
package gsbt_pkg;
   typedef enum logic [1:0] {
      GSBT_SRC_INSTR,
      GSBT_SRC_SYS,
      GSBT_SRC_PIN,
      GSBT_SRC_CAPS
   } gsbt_src_t;
   typedef enum {
      GSBT_ARM_WAIT_LOW,
      GSBT_ARM_READY
   } gsbt_arm_t;
endpackage : gsbt_pkg

// file: rtl/gsbt_tick_if.sv
// tick carrier between the edge front end, prescaler and counter
`timescale 1ns/1ps
interface gsbt_tick_if;
   logic tick;    // one-cycle count pulse
   logic clear;   // clears prescaler and re-arms edge logic
   modport src (output tick, input clear);
   modport dst (input tick, output clear);
endinterface : gsbt_tick_if

// file: rtl/gsbt_edge.sv
// external source edge front end with optional synchroniser
`timescale 1ns/1ps
module gsbt_edge (
   input  wire logic   clk,           // system clock
   input  wire logic   rst_n,         // sync reset, active low
   input  wire logic   ext_level,     // selected external source level
   input  wire logic   no_sync,       // bypass the synchroniser
   input  wire logic   enable,        // timer on
   gsbt_tick_if.src    tick_o         // rising edge pulse out
);
   logic              sync1_q, sync1_d;
   logic              sync2_q, sync2_d;
   logic              prev_q,  prev_d;
   gsbt_pkg::gsbt_arm_t arm_q, arm_d;
   logic              lvl;

   // two-flop synchroniser is the safe path; bypass trades safety for latency
   always_comb begin
      sync1_d = ext_level;
      sync2_d = sync1_q;
      lvl     = no_sync ? ext_level : sync2_q;
      prev_d  = lvl;
      arm_d   = arm_q;
      tick_o.tick = 1'b0;
      if (!enable || tick_o.clear) begin
         arm_d = gsbt_pkg::GSBT_ARM_WAIT_LOW;
      end else begin
         case (arm_q)
            gsbt_pkg::GSBT_ARM_WAIT_LOW: if (!lvl) arm_d = gsbt_pkg::GSBT_ARM_READY;
            gsbt_pkg::GSBT_ARM_READY: tick_o.tick = lvl && !prev_q;
            default: arm_d = gsbt_pkg::GSBT_ARM_WAIT_LOW;
         endcase
      end
   end

   // edge state registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
         arm_q   <= gsbt_pkg::GSBT_ARM_WAIT_LOW;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
         arm_q   <= arm_d;
      end
   end
endmodule : gsbt_edge

// file: rtl/gsbt_presc.sv
// 1/2/4/8 prescaler on count ticks
`timescale 1ns/1ps
module gsbt_presc (
   input  wire logic   clk,           // system clock
   input  wire logic   rst_n,         // sync reset, active low
   input  wire logic [1:0] ratio,     // prescale select code
   gsbt_tick_if.dst    tick_i,        // raw ticks in, clear out
   input  wire logic   clr,           // count byte written
   output logic        o_tick         // divided tick
);
   logic [2:0] cnt_q, cnt_d;
   logic [2:0] lim;

   // code n divides by two to the n
   function automatic logic [2:0] div_limit(input logic [1:0] code);
      case (code)
         2'h0:    div_limit = 3'h0;
         2'h1:    div_limit = 3'h1;
         2'h2:    div_limit = 3'h3;
         default: div_limit = 3'h7;
      endcase
   endfunction : div_limit

   // prescale counter is hidden from software and cleared by count writes
   always_comb begin
      lim          = div_limit(ratio);
      tick_i.clear = clr;
      o_tick       = 1'b0;
      cnt_d        = cnt_q;
      if (clr) begin
         cnt_d = 3'h0;
      end else if (tick_i.tick) begin
         if (cnt_q >= lim) begin
            cnt_d  = 3'h0;
            o_tick = 1'b1;
         end else begin
            cnt_d = cnt_q + 3'h1;
         end
      end
   end

   // prescale register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : gsbt_presc

// file: rtl/gsbt_timer.sv
// top of the gated sixteen-bit timer with its apb register slave
//
// Function
// - sixteen-bit up-counter seen by software as high and low bytes
// - writing a count byte replaces that byte of the counter at once
// - instruction clock advances once per cycle; external advances per selected edge
// - off when timer_on low; always counts without gate_enable; gated otherwise
// - source_select picks instruction, system, external pin or sensing oscillator
// - system clock source adds four counts per instruction cycle
// - external sources count on rising edges
// - external source may be synchronised or used without synchroniser
// - a falling edge must precede first counted rise after enable or write
// - selected clock divided by 1, 2, 4 or 8 before counting
// - prescaler hidden from software, cleared by any count byte write
// - crystal_osc_enable starts the crystal oscillator, which runs through sleep
// - no_sync_select passes the external clock without synchronisation
// - asynchronous external counting continues in sleep, overflow wakes
// - switching sync mode may lose or add one increment
// - counter rolls from all ones to zero and sets the overflow flag
// - count byte reads return a stable value while counting asynchronously
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "gsbt_defs.svh"
module gsbt_timer (
   input  wire logic        I_SYS_CLK,       // 100 MHz system clock
   input  wire logic        I_RESET_N,       // sync reset, active low
   input  wire logic        I_PSEL,          // apb select
   input  wire logic        I_PENABLE,       // apb access phase
   input  wire logic        I_PWRITE,        // apb direction
   input  wire logic [11:0] I_PADDR,         // apb byte address
   input  wire logic [31:0] I_PWDATA,        // apb write data
   output logic      [31:0] O_PRDATA,        // apb read data
   output logic             O_PREADY,        // apb ready
   output logic             O_PSLVERR,       // apb error
   input  wire logic        I_EXT_COUNT_CLOCK_PIN, // external count clock
   input  wire logic        I_CAPS_OSC,      // capacitive sensing oscillator
   input  wire logic        I_CRYSTAL_IN_PIN, // crystal oscillator input
   output logic             O_CRYSTAL_OUT_PIN, // crystal amplifier output
   input  wire logic        I_GATE_PERMIT,   // gate permit from gate logic
   input  wire logic        I_SLEEP,         // processor asleep
   output logic             O_OVERFLOW_FLAG, // overflow flag level
   output logic             O_WAKE           // wake request, one-cycle pulse
);
   logic [7:0]  ctl_q, ctl_d;
   logic [15:0] cnt_q, cnt_d;
   logic        ovf_q, ovf_d;
   logic [1:0]  icyc_q, icyc_d;
   logic [3:0]  sel;
   logic        step, roll;
   logic        wake_q, wake_d;
   logic [31:0] rdata_q, rdata_d;
   logic        slverr_q, slverr_d;
   logic [9:0]  osc_cnt_q, osc_cnt_d;
   logic        osc_run_q, osc_run_d;
   logic        osc_prev_q, osc_prev_d;
   logic        timer_on, gate_en, no_sync, osc_en;
   logic [1:0]  presc_sel;
   gsbt_pkg::gsbt_src_t src;
   logic        wr_low, wr_high, wr_ctl, wr_sts, apb_acc, addr_ok;
   logic        ext_level, ext_sel, raw_tick, div_tick, run, instr_pulse, inc;
   logic        sync_hold;
   logic        pre_tick;

   gsbt_tick_if tick_bus ();

   // control field decode
   assign timer_on  = ctl_q[`GSBT_CTL_TIMER_ON];
   assign gate_en   = ctl_q[`GSBT_CTL_GATE_EN];
   assign no_sync   = ctl_q[`GSBT_CTL_NO_SYNC];
   assign osc_en    = ctl_q[`GSBT_CTL_OSC_EN];
   assign presc_sel = ctl_q[`GSBT_CTL_PRESC_LSB +: 2];
   assign src       = gsbt_pkg::gsbt_src_t'(ctl_q[`GSBT_CTL_SRC_LSB +: 2]);

   // register map, one aligned word each, byte data in bits 7:0
   //    control: timer_on 0, gate_enable 1, no_sync_select 2,
   //             crystal_osc_enable 3, prescale_select 5:4, source_select 7:6
   //    count low, count high: live counter bytes, written directly
   //    status: overflow_flag 0 (write 0 clears), crystal running 1
   // one-hot register select, shared by write strobes and error check
   function automatic logic [3:0] reg_sel(input logic [11:0] addr);
      case (addr)
         `GSBT_ADDR_CONTROL:    reg_sel = 4'h1;
         `GSBT_ADDR_COUNT_LOW:  reg_sel = 4'h2;
         `GSBT_ADDR_COUNT_HIGH: reg_sel = 4'h4;
         `GSBT_ADDR_STATUS:     reg_sel = 4'h8;
         default:               reg_sel = 4'h0;
      endcase
   endfunction : reg_sel

   // apb decode; zero wait states because read data is staged in the setup cycle
   assign sel     = reg_sel(I_PADDR);
   assign apb_acc = I_PSEL && I_PENABLE;
   assign addr_ok = |sel;
   assign wr_ctl  = apb_acc && I_PWRITE && sel[0];
   assign wr_low  = apb_acc && I_PWRITE && sel[1];
   assign wr_high = apb_acc && I_PWRITE && sel[2];
   assign wr_sts  = apb_acc && I_PWRITE && sel[3];
   assign O_PREADY  = 1'b1;
   assign O_PRDATA  = rdata_q;
   assign O_PSLVERR = slverr_q;

   // external source choice; crystal drives the pin path when enabled
   assign ext_sel   = (src == gsbt_pkg::GSBT_SRC_PIN) || (src == gsbt_pkg::GSBT_SRC_CAPS);
   assign ext_level = (src == gsbt_pkg::GSBT_SRC_CAPS) ? I_CAPS_OSC :
                      (osc_en ? I_CRYSTAL_IN_PIN : I_EXT_COUNT_CLOCK_PIN);

   // crystal amplifier only inverts the input while enabled
   assign O_CRYSTAL_OUT_PIN = osc_en ? ~I_CRYSTAL_IN_PIN : 1'b0;

   // switching no_sync_select mid-count may gain or lose one step; callers tolerate it
   gsbt_edge u_edge (
      .clk       (I_SYS_CLK),
      .rst_n     (I_RESET_N),
      .ext_level (ext_level),
      .no_sync   (no_sync),
      .enable    (timer_on && ext_sel),
      .tick_o    (tick_bus)
   );

   // internal sources feed the prescaler directly; system clock ticks every cycle
   always_comb begin
      instr_pulse = (icyc_q == `GSBT_INSTR_DIV);
      case (src)
         gsbt_pkg::GSBT_SRC_INSTR: pre_tick = instr_pulse;
         gsbt_pkg::GSBT_SRC_SYS:   pre_tick = 1'b1;
         default:                  pre_tick = tick_bus.tick;
      endcase
      raw_tick = pre_tick && timer_on;
   end

   // prescaler sees raw ticks via a second carrier
   gsbt_tick_if presc_bus ();
   assign presc_bus.tick = raw_tick;

   gsbt_presc u_presc (
      .clk    (I_SYS_CLK),
      .rst_n  (I_RESET_N),
      .ratio  (presc_sel),
      .tick_i (presc_bus),
      .clr    (wr_low || wr_high),
      .o_tick (div_tick)
   );
   assign tick_bus.clear = presc_bus.clear;

   // gate only matters when both enables are set
   assign run = timer_on && (!gate_en || I_GATE_PERMIT);
   assign inc = div_tick && run;
   // sleep stops all sources except asynchronous external counting
   assign sync_hold = I_SLEEP && !(no_sync && ext_sel);

   // a counted step is dropped while sleep freezes the synchronous sources,
   // so only asynchronous external counting can roll over in sleep
   assign step = inc && !sync_hold;
   assign roll = step && (cnt_q == 16'hffff);

   // instruction phase runs free; count writes do not realign it,
   // so the first instruction tick after a write may come early
   always_comb begin
      icyc_d = icyc_q + 2'h1;
   end

   // instruction phase register
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         icyc_q <= 2'h0;
      end else begin
         icyc_q <= icyc_d;
      end
   end

   // counter next value; a byte write replaces its byte, and the prescaler
   // clear drops any same-cycle step, so the other byte holds its value
   always_comb begin
      cnt_d = cnt_q;
      if (step) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wr_low) begin
         cnt_d[7:0] = I_PWDATA[7:0];
      end
      if (wr_high) begin
         cnt_d[15:8] = I_PWDATA[7:0];
      end
   end

   // counter register
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // overflow flag and wake request; a rollover in the same cycle
   // as a software clear wins, so no overflow is ever lost
   always_comb begin
      ovf_d  = ovf_q;
      wake_d = 1'b0;
      if (wr_sts && !I_PWDATA[`GSBT_STS_OVF]) begin
         ovf_d = 1'b0;
      end
      if (roll) begin
         ovf_d  = 1'b1;
         wake_d = I_SLEEP;
      end
   end

   // flag and wake registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         ovf_q  <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         ovf_q  <= ovf_d;
         wake_q <= wake_d;
      end
   end

   // crystal running indicator: counts settle edges after enable
   always_comb begin
      osc_prev_d = I_CRYSTAL_IN_PIN;
      osc_cnt_d  = osc_cnt_q;
      osc_run_d  = osc_run_q;
      if (!osc_en) begin
         osc_cnt_d = 10'h000;
         osc_run_d = 1'b0;
      end else if (I_CRYSTAL_IN_PIN && !osc_prev_q && !osc_run_q) begin
         osc_cnt_d = osc_cnt_q + 10'h001;
         osc_run_d = (osc_cnt_q == `GSBT_OSC_SETTLE);
      end
   end

   // crystal indicator registers; the edge history runs even while
   // disabled, so enabling never sees a stale rise
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         osc_cnt_q  <= 10'h000;
         osc_run_q  <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_cnt_q  <= osc_cnt_d;
         osc_run_q  <= osc_run_d;
         osc_prev_q <= osc_prev_d;
      end
   end

   // control register, written at the access edge
   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = I_PWDATA[7:0] & `GSBT_CTL_MASK;
      end
   end

   // control register
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         ctl_q <= `GSBT_CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // read data and error are staged in the setup cycle so they stand
   // through the access edge with no wait state; the count bytes are
   // a snapshot of that cycle, so a read never sees a half-carried value
   always_comb begin
      rdata_d  = rdata_q;
      slverr_d = 1'b0;
      if (I_PSEL && !I_PENABLE) begin
         slverr_d = !addr_ok;
         if (!I_PWRITE) begin
            case (I_PADDR)
               `GSBT_ADDR_CONTROL:    rdata_d = {24'h000000, ctl_q};
               `GSBT_ADDR_COUNT_LOW:  rdata_d = {24'h000000, cnt_q[7:0]};
               `GSBT_ADDR_COUNT_HIGH: rdata_d = {24'h000000, cnt_q[15:8]};
               `GSBT_ADDR_STATUS:     rdata_d = {30'h00000000, osc_run_q, ovf_q};
               default:               rdata_d = 32'h00000000;
            endcase
         end
      end
   end

   // read data and error registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         rdata_q  <= 32'h00000000;
         slverr_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         slverr_q <= slverr_d;
      end
   end

   // flag is a level; wake is one cycle wide
   assign O_OVERFLOW_FLAG = ovf_q;
   assign O_WAKE          = wake_q;
endmodule : gsbt_timer

// file: tb/gsbt_timer_sva.sv
// port checker for the gated sixteen-bit timer
`timescale 1ns/1ps
`include "gsbt_defs.svh"
module gsbt_timer_chk (
   input wire logic        I_SYS_CLK,         // clock
   input wire logic        I_RESET_N,         // reset, low
   input wire logic        I_PSEL,            // select
   input wire logic        I_PENABLE,         // access
   input wire logic        I_PWRITE,          // direction
   input wire logic [11:0] I_PADDR,           // address
   input wire logic [31:0] I_PWDATA,          // write data
   input wire logic [31:0] O_PRDATA,          // read data
   input wire logic        O_PREADY,          // ready
   input wire logic        O_PSLVERR,         // error
   input wire logic        I_CRYSTAL_IN_PIN,  // crystal in
   input wire logic        O_CRYSTAL_OUT_PIN, // crystal out
   input wire logic        I_SLEEP,           // asleep
   input wire logic        O_OVERFLOW_FLAG,   // flag
   input wire logic        O_WAKE             // wake pulse
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESET_N);
   logic acc;
   logic mapd;
   logic clr;
   // access decode; only four aligned words answer
   assign acc  = I_PSEL && I_PENABLE;
   assign mapd = I_PADDR[11:4] == 8'h00 && I_PADDR[1:0] == 2'h0;
   assign clr  = acc && I_PWRITE && I_PADDR == `GSBT_ADDR_STATUS && !I_PWDATA[0];
   sequence s_bad; acc && !mapd; endsequence
   sequence s_cnt_rd; acc && mapd && !I_PWRITE && I_PADDR[3] != I_PADDR[2]; endsequence
   property p_ready; acc |-> O_PREADY; endproperty
   property p_bad; s_bad |-> O_PSLVERR; endproperty
   property p_bad_rd; s_bad ##0 !I_PWRITE |-> O_PRDATA == 32'h0; endproperty
   property p_good; acc && mapd |-> !O_PSLVERR; endproperty
   property p_byte; s_cnt_rd |-> O_PRDATA[31:8] == 24'h0; endproperty
   property p_sticky; O_OVERFLOW_FLAG && !clr |=> O_OVERFLOW_FLAG; endproperty
   property p_clear; $fell(O_OVERFLOW_FLAG) |-> $past(clr); endproperty
   property p_wake_one; O_WAKE |=> !O_WAKE; endproperty
   property p_wake_slp; O_WAKE |-> $past(I_SLEEP) && O_OVERFLOW_FLAG; endproperty
   property p_xtal; O_CRYSTAL_OUT_PIN |-> !I_CRYSTAL_IN_PIN; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   a_bad: assert property (p_bad) else $error("no error on unmapped access");
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
   a_good: assert property (p_good) else $error("error on mapped access");
   a_byte: assert property (p_byte) else $error("count read wider than a byte");
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
   a_clear: assert property (p_clear) else $error("flag fell with no clear write");
   a_wake_one: assert property (p_wake_one) else $error("wake longer than a cycle");
   a_wake_slp: assert property (p_wake_slp) else $error("wake without sleep or flag");
   a_xtal: assert property (p_xtal) else $error("crystal out not inverted");
endmodule : gsbt_timer_chk
bind gsbt_timer gsbt_timer_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CRYSTAL_IN_PIN(I_CRYSTAL_IN_PIN),
   .O_CRYSTAL_OUT_PIN(O_CRYSTAL_OUT_PIN), .I_SLEEP(I_SLEEP), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
   .O_WAKE(O_WAKE));

// file: tb/gsbt_ext_src.sv
// behavioural external count source, idle low between bursts
`timescale 1ns/1ps
module gsbt_ext_src #(
   parameter int HALF = 3                // clock cycles per half period
) (
   input  wire logic        i_clk,       // bench clock
   input  wire logic [11:0] i_n,         // rising edges to send
   input  wire logic        i_go,        // start a burst
   output logic             o_level,     // source level
   output logic             o_busy       // burst running
);
   initial o_level = 1'h0;
   initial o_busy = 1'h0;
   // each rise follows a low phase, so a fall is always seen first
   always @(posedge i_go) begin
      o_busy <= 1'h1;
      repeat (i_n) begin
         repeat (HALF) @(posedge i_clk);
         o_level <= 1'h1;
         repeat (HALF) @(posedge i_clk);
         o_level <= 1'h0;
      end
      o_busy <= 1'h0;
   end
endmodule : gsbt_ext_src

// file: tb/tb_gated_sixteen_bit_timer.sv
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps
`include "gsbt_defs.svh"
module tb_gated_sixteen_bit_timer;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        psel = 1'h0;
   logic        pen = 1'h0;
   logic        pwr = 1'h0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic        perm = 1'h0;
   logic        slp = 1'h0;
   logic [2:0]  go = 3'h0;
   logic [11:0] nx = 12'h000;
   logic        woke = 1'h0;
   wire  [2:0]  busy, src;
   logic [31:0] prd, d;
   logic        rdy, serr, xo, flag, wake, e;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          s, p, x;
   gsbt_timer dut_u (
      .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(serr),
      .I_EXT_COUNT_CLOCK_PIN(src[0]), .I_CAPS_OSC(src[1]), .I_CRYSTAL_IN_PIN(src[2]),
      .O_CRYSTAL_OUT_PIN(xo), .I_GATE_PERMIT(perm), .I_SLEEP(slp), .O_OVERFLOW_FLAG(flag), .O_WAKE(wake));
   // pin, sensing oscillator and crystal, each at its own speed
   for (genvar i = 0; i < 3; i++) begin : g_src
      gsbt_ext_src #(.HALF(i + 2)) src_u (.i_clk(clk), .i_n(nx), .i_go(go[i]), .o_level(src[i]),
         .o_busy(busy[i]));
   end
   always #5 clk = ~clk;
   // wake capture and run ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wake === 1'h1) woke <= 1'h1;
      if (cyc == 30000) begin
         err_count++;
         stop_test();
      end
   end
   task stop_test;
      if (err_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // wait for pready with the request held; only the run ceiling ends it
   task wt;
      do begin
         @(posedge clk);
      end while (rdy !== 1'h1);
   endtask : wt
   task wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      psel <= 1'h1; pen <= 1'h0; pwr <= 1'h1; padr <= a; pwd <= {24'h0, v};
      @(posedge clk);
      pen <= 1'h1;
      wt();
      psel <= 1'h0; pen <= 1'h0;
   endtask : wr
   // read data and error stand through the access cycle and are taken at its edge
   task rd(input logic [11:0] a, output logic [31:0] v, output logic er);
      @(posedge clk);
      psel <= 1'h1; pen <= 1'h0; pwr <= 1'h0; padr <= a;
      @(posedge clk);
      pen <= 1'h1;
      wt();
      v = prd;
      er = serr;
      psel <= 1'h0; pen <= 1'h0;
   endtask : rd
   task burst(input logic [1:0] w, input logic [11:0] n);
      @(posedge clk);
      nx <= n; go <= 3'h1 << w;
      @(posedge clk);
      go <= 3'h0;
      for (int k = 0; k < 20000; k++) begin
         @(posedge clk);
         if (busy === 3'h0) break;
      end
      repeat (4) @(posedge clk); // covers the two-flop synchroniser
   endtask : burst
   // count from zero for 65 cycles or one burst, then stop and read
   task run(input logic [7:0] ctl, input logic [1:0] w, input logic [11:0] n, input int lo, input int hi);
      wr(`GSBT_ADDR_COUNT_LOW, 8'h00);
      wr(`GSBT_ADDR_COUNT_HIGH, 8'h00);
      wr(`GSBT_ADDR_CONTROL, ctl);
      if (w == 2'h3) repeat (62) @(posedge clk);
      else burst(w, n);
      wr(`GSBT_ADDR_CONTROL, 8'h00);
      rd(`GSBT_ADDR_COUNT_LOW, d, e);
      n_checks++;
      if ((d[7:0] >= lo && d[7:0] <= hi) !== 1'h1) begin
         err_count++;
         $display("BAD %0t count %h outside %0d..%0d", $time, d[7:0], lo, hi);
      end
   endtask : run
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      for (s = 0; s < 16; s += 4) begin
         rd(s[11:0], d, e);
         chk(d, 32'h0);
      end
      wr(`GSBT_ADDR_COUNT_HIGH, 8'h12);
      wr(`GSBT_ADDR_COUNT_LOW, 8'h34);
      rd(`GSBT_ADDR_COUNT_HIGH, d, e);
      chk(d, 32'h12);
      rd(`GSBT_ADDR_COUNT_LOW, d, e);
      chk(d, 32'h34);
      for (s = 0; s < 2; s++) begin
         for (p = 0; p < 4; p++) begin
            x = (s == 1 ? 64 : 16) >> p;
            run({s[1:0], p[1:0], 4'h1}, 2'h3, 12'h000, x - 1, x + 1);
         end
      end
      run(8'h43, 2'h3, 12'h000, 0, 0);
      perm <= 1'h1;
      run(8'h43, 2'h3, 12'h000, 63, 65);
      run(8'h42, 2'h3, 12'h000, 0, 0);
      run(8'h81, 2'h0, 12'h00a, 10, 10);
      run(8'h85, 2'h0, 12'h00a, 10, 10);
      run(8'hc1, 2'h1, 12'h007, 7, 7);
      run(8'he5, 2'h1, 12'h00c, 3, 3);
      wr(`GSBT_ADDR_COUNT_HIGH, 8'hfc);
      wr(`GSBT_ADDR_COUNT_LOW, 8'h00);
      wr(`GSBT_ADDR_CONTROL, 8'h8d);
      burst(2'h2, 12'h3ff);
      rd(`GSBT_ADDR_STATUS, d, e);
      chk(d & 32'h1, 32'h0);
      slp <= 1'h1;
      burst(2'h2, 12'h001);
      chk({31'h0, flag}, 32'h1);
      chk({31'h0, woke}, 32'h1);
      chk({31'h0, xo}, {31'h0, ~src[2]});
      slp <= 1'h0;
      rd(`GSBT_ADDR_STATUS, d, e);
      chk(d, 32'h3);
      rd(`GSBT_ADDR_COUNT_HIGH, d, e);
      chk(d, 32'h0);
      rd(`GSBT_ADDR_COUNT_LOW, d, e);
      chk(d, 32'h0);
      wr(`GSBT_ADDR_STATUS, 8'h00);
      rd(`GSBT_ADDR_STATUS, d, e);
      chk(d, 32'h2);
      rd(12'h010, d, e);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h1);
      stop_test();
   end
endmodule : tb_gated_sixteen_bit_timer
